// >>> shared/adc_readout_pkg.sv
// Purpose: Shared constants and carrier types for the converter result readout port
// Assumes: One clock (clk) paces the modulator, filter cadence and readout
// Notes: Counts are in clk cycles; the modulator tick is clk divided down

package adc_readout_pkg;

    // Result word
    localparam int RESULT_W = 24;
    localparam int BITCNT_W = 5;
    localparam logic [BITCNT_W-1:0] BITCNT_LAST = BITCNT_W'(RESULT_W);

    // Nominal pacing: system clock to result rate
    localparam longint NOM_SYSCLK_HZ = 64'd16000000;
    localparam int MOD_DIV = 6;
    localparam int OSR = 64;
    localparam int RESULT_CLKS = MOD_DIV * OSR;
    localparam longint NOM_RESULT_HZ = NOM_SYSCLK_HZ / RESULT_CLKS;

    // Divider and oversampling counters
    localparam int DIV_W = 3;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);
    localparam int OSR_W = 6;
    localparam logic [OSR_W-1:0] OSR_LAST = OSR_W'(OSR - 1);

    // Filter settling
    localparam int SETTLE_W = 3;
    localparam logic [SETTLE_W-1:0] SETTLE_CONV = 3'h5;
    localparam int SETTLE_CLKS = 5 * RESULT_CLKS;
    localparam int RUN_W = 12;

    // Serial clock held-high thresholds, in clk cycles
    localparam int TIMER_W = 16;
    localparam logic [TIMER_W-1:0] SYNC_HIGH_DEF = 16'h0600;
    localparam logic [TIMER_W-1:0] PD_HIGH_DEF = 16'h0f00;

    // Readout states
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_READY,
        RD_SHIFT
    } rd_state_t;

    // Status carried out of the block
    typedef struct packed {
        logic modTick;
        logic convDone;
        logic settled;
        logic modReset;
        logic powerDown;
    } status_t;

endpackage

// >>> rtl/sclk_high_timer.sv
// Purpose: Measure how long the serial clock stays high
// Assumes: sclk already synchronous to clk
// Notes: Counter saturates at the power-down threshold

`timescale 1ns/10ps

module sclk_high_timer import adc_readout_pkg::*; #(
    parameter logic [TIMER_W-1:0] SYNC_HIGH = SYNC_HIGH_DEF,
    parameter logic [TIMER_W-1:0] PD_HIGH = PD_HIGH_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Serial clock level
    input wire logic sclk,
    // Requests
    output logic syncReq,
    output logic pdActive
);

    logic [TIMER_W-1:0] hiCnt_q;
    logic [TIMER_W-1:0] hiCnt_d;

    always_comb begin
        hiCnt_d = hiCnt_q;
        if (!sclk) begin
            hiCnt_d = '0;
        end else if (hiCnt_q != PD_HIGH) begin
            hiCnt_d = hiCnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hiCnt_q <= '0;
        end else begin
            hiCnt_q <= hiCnt_d;
        end
    end

    // One pulse at the sync threshold, level once past power-down one
    assign syncReq = sclk && (hiCnt_q == SYNC_HIGH - 16'h0001);
    assign pdActive = (hiCnt_q == PD_HIGH);

endmodule

// >>> rtl/adc_result_readout_port.sv
// Purpose: Result register, data/ready pin and serial readout of a delta-sigma converter
// Assumes: sclk and filterWord synchronous to clk; filter arithmetic lives outside
// Notes: Long sclk high resets the modulator or powers down

`timescale 1ns/10ps

module adc_result_readout_port import adc_readout_pkg::*; #(
    parameter logic [TIMER_W-1:0] SYNC_HIGH = SYNC_HIGH_DEF,
    parameter logic [TIMER_W-1:0] PD_HIGH = PD_HIGH_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Filter output
    input wire logic [RESULT_W-1:0] filterWord,
    // Serial pins
    input wire logic sclk,
    output logic dataOutReadyN,
    // Status
    output status_t status
);

    logic syncReq;
    logic pdActive;
    logic halt;
    logic modTick;
    logic convDone;
    logic settled;
    logic sclkRise;
    logic sclkFall;

    logic [DIV_W-1:0] divCnt_q, divCnt_d;
    logic [OSR_W-1:0] modCnt_q, modCnt_d;
    logic [SETTLE_W-1:0] settleCnt_q, settleCnt_d;
    logic [RESULT_W-1:0] outReg_q, outReg_d;
    logic [RESULT_W-1:0] shift_q, shift_d;
    logic [BITCNT_W-1:0] bitCnt_q, bitCnt_d;
    logic stored_q, stored_d;
    logic fresh_q, fresh_d;
    logic sclkPrev_q, sclkPrev_d;
    logic pin_q, pin_d;
    rd_state_t state_q, state_d;

    sclk_high_timer #(
        .SYNC_HIGH(SYNC_HIGH),
        .PD_HIGH(PD_HIGH)
    ) u_timer (
        .clk(clk),
        .srst(srst),
        .sclk(sclk),
        .syncReq(syncReq),
        .pdActive(pdActive)
    );

    // Modulator reset or power-down stops the whole cadence
    assign halt = syncReq || pdActive;
    assign modTick = (divCnt_q == DIV_LAST);
    assign convDone = modTick && (modCnt_q == OSR_LAST);
    assign settled = (settleCnt_q == SETTLE_CONV);
    // Edges of the serial clock, sampled every clk
    assign sclkRise = sclk && !sclkPrev_q;
    assign sclkFall = !sclk && sclkPrev_q;

    // Cadence: divider, oversampling count, settling
    always_comb begin
        divCnt_d = divCnt_q + 3'h1;
        modCnt_d = modCnt_q;
        settleCnt_d = settleCnt_q;
        if (modTick) begin
            divCnt_d = '0;
            modCnt_d = modCnt_q + 6'h01;
        end
        if (convDone && !settled) begin
            settleCnt_d = settleCnt_q + 3'h1;
        end
        if (halt) begin
            divCnt_d = '0;
            modCnt_d = '0;
            settleCnt_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            divCnt_q <= '0;
            modCnt_q <= '0;
            settleCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_d;
            modCnt_q <= modCnt_d;
            settleCnt_q <= settleCnt_d;
        end
    end

    // Output register, readout machine and pin
    always_comb begin
        outReg_d = outReg_q;
        stored_d = 1'b0;
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        state_d = state_q;
        pin_d = pin_q;
        sclkPrev_d = sclk;
        if (convDone) begin
            outReg_d = filterWord;
            stored_d = 1'b1;
        end
        // A new store beats the clear taken at read start
        fresh_d = stored_q || (fresh_q && !(state_q == RD_READY && sclkRise));
        unique case (state_q)
            RD_IDLE: begin
                if (fresh_q) begin
                    state_d = RD_READY;
                    pin_d = 1'b0;
                end
            end
            RD_READY: begin
                pin_d = 1'b0;
                if (sclkRise) begin
                    pin_d = outReg_q[RESULT_W-1];
                    shift_d = {outReg_q[RESULT_W-2:0], 1'b0};
                    bitCnt_d = 5'h01;
                    state_d = RD_SHIFT;
                end
            end
            RD_SHIFT: begin
                if (sclkRise) begin
                    pin_d = shift_q[RESULT_W-1];
                    shift_d = {shift_q[RESULT_W-2:0], 1'b0};
                    bitCnt_d = bitCnt_q + 5'h01;
                end else if (sclkFall && bitCnt_q == BITCNT_LAST) begin
                    state_d = fresh_q ? RD_READY : RD_IDLE;
                    pin_d = !fresh_q;
                end
            end
        endcase
        if (halt) begin
            state_d = RD_IDLE;
            pin_d = 1'b1;
            fresh_d = 1'b0;
            stored_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            outReg_q <= '0;
            stored_q <= 1'b0;
            fresh_q <= 1'b0;
            shift_q <= '0;
            bitCnt_q <= '0;
            state_q <= RD_IDLE;
            pin_q <= 1'b1;
            sclkPrev_q <= 1'b0;
        end else begin
            outReg_q <= outReg_d;
            stored_q <= stored_d;
            fresh_q <= fresh_d;
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            state_q <= state_d;
            pin_q <= pin_d;
            sclkPrev_q <= sclkPrev_d;
        end
    end

    assign dataOutReadyN = pin_q;
    assign status.modTick = modTick;
    assign status.convDone = convDone;
    assign status.settled = settled;
    assign status.modReset = syncReq;
    assign status.powerDown = pdActive;

    // Helper counters for the checks below
    logic [RUN_W-1:0] runCnt_q, runCnt_d;
    logic [RUN_W-1:0] gapCnt_q, gapCnt_d;
    logic gapValid_q, gapValid_d;

    always_comb begin
        runCnt_d = (runCnt_q == '1) ? runCnt_q : runCnt_q + 12'h001;
        gapCnt_d = convDone ? '0 : gapCnt_q + 12'h001;
        gapValid_d = gapValid_q || convDone;
        if (halt) begin
            runCnt_d = '0;
            gapCnt_d = '0;
            gapValid_d = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            runCnt_q <= '0;
            gapCnt_q <= '0;
            gapValid_q <= 1'b0;
        end else begin
            runCnt_q <= runCnt_d;
            gapCnt_q <= gapCnt_d;
            gapValid_q <= gapValid_d;
        end
    end

    property p_div_period;
        @(posedge clk) disable iff (srst || halt)
        modTick |=> !modTick [*5] ##1 modTick;
    endproperty
    a_div_period: assert property (p_div_period) else $error("modulator tick not every 6 clocks");

    property p_conv_period;
        @(posedge clk) disable iff (srst || halt)
        convDone && gapValid_q |-> gapCnt_q == RUN_W'(RESULT_CLKS - 1);
    endproperty
    a_conv_period: assert property (p_conv_period) else $error("result period not 384 clocks");

    property p_settle;
        @(posedge clk) disable iff (srst || halt)
        $rose(settled) |-> runCnt_q == RUN_W'(SETTLE_CLKS);
    endproperty
    a_settle: assert property (p_settle) else $error("settled flag not at 1920 clocks");

    property p_store_first;
        @(posedge clk) disable iff (srst || halt)
        convDone && state_q == RD_IDLE && !fresh_q |=>
            outReg_q == $past(filterWord) && dataOutReadyN ##2 !dataOutReadyN;
    endproperty
    a_store_first: assert property (p_store_first) else $error("pin fell before word stored");

    property p_ready_low;
        @(posedge clk) disable iff (srst)
        state_q == RD_READY |-> !dataOutReadyN;
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("pin high while word waiting");

    property p_msb_first;
        @(posedge clk) disable iff (srst || halt)
        state_q == RD_READY && sclkRise |=> dataOutReadyN == $past(outReg_q[RESULT_W-1]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit is not the MSB");

    property p_shift_bit;
        @(posedge clk) disable iff (srst || halt)
        state_q == RD_SHIFT && sclkRise |=> dataOutReadyN == $past(shift_q[RESULT_W-1]);
    endproperty
    a_shift_bit: assert property (p_shift_bit) else $error("wrong bit on serial edge");

    property p_sync_reset;
        @(posedge clk) disable iff (srst)
        syncReq |=> divCnt_q == '0 && modCnt_q == '0 && state_q == RD_IDLE && dataOutReadyN;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("sync did not reset modulator");

    property p_power_down;
        @(posedge clk) disable iff (srst)
        pdActive ##1 pdActive |-> dataOutReadyN && !convDone && settleCnt_q == '0;
    endproperty
    a_power_down: assert property (p_power_down) else $error("activity during power-down");

endmodule

// >>> verif/host_reader_model.sv
// Purpose: Host that clocks result words out of the readout port
// Assumes: One clk domain; the bench calls the tasks
// Notes: sclk changes just after a clk edge only

`timescale 1ns/10ps

module host_reader_model import adc_readout_pkg::*; (
    // Clock
    input wire logic clk,
    // Serial pins
    input wire logic dataOutReadyN,
    output logic sclk
);
    initial begin
        sclk = 1'b0;
    end

    // Shift nBits out, half clk cycles per phase
    task automatic read_bits(input int nBits, input int half, output logic [RESULT_W-1:0] word);
        word = '0;
        for (int i = 0; i < nBits; i++) begin
            @(posedge clk);
            sclk <= 1'b1;
            repeat (half) @(posedge clk);
            sclk <= 1'b0;
            #1 word = {word[RESULT_W-2:0], dataOutReadyN};
            repeat (half - 1) @(posedge clk);
        end
    endtask

    // Hold sclk high for n clk cycles
    task automatic hold_high(input int n);
        @(posedge clk);
        sclk <= 1'b1;
        repeat (n) @(posedge clk);
        sclk <= 1'b0;
    endtask
endmodule

// >>> verif/adc_result_readout_port_tb_top.sv
// Purpose: Self-checking bench for the result readout port
// Assumes: Small held-high thresholds of 16 and 40 clk cycles
// Notes: Outputs are sampled 1 ns after the clk edge

`timescale 1ns/10ps

module adc_result_readout_port_tb_top import adc_readout_pkg::*; ;
    localparam logic [TIMER_W-1:0] SYNC_T = 16'h0010;
    localparam logic [TIMER_W-1:0] PD_T = 16'h0028;
    logic clk;
    logic srst;
    logic [RESULT_W-1:0] filterWord;
    logic sclk;
    logic dataOutReadyN;
    status_t status;
    int err_count;
    int cmp_count;
    int modCnt;
    int pdCnt;
    logic [RESULT_W-1:0] got;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    adc_result_readout_port #(.SYNC_HIGH(SYNC_T), .PD_HIGH(PD_T)) adc_result_readout_port_i (
        .clk(clk), .srst(srst), .filterWord(filterWord), .sclk(sclk),
        .dataOutReadyN(dataOutReadyN), .status(status));

    host_reader_model host_reader_model_i (
        .clk(clk), .dataOutReadyN(dataOutReadyN), .sclk(sclk));

    // Pulse and level counters
    always @(posedge clk) begin
        if (status.modReset === 1'b1) modCnt <= modCnt + 1;
        if (status.powerDown === 1'b1) pdCnt <= pdCnt + 1;
    end

    task automatic chk(input logic [31:0] gotV, input logic [31:0] expV);
        cmp_count++;
        if (gotV !== expV) begin
            err_count++;
            $display("[ERR] t=%0t got %h expected %h", $time, gotV, expV);
        end
    endtask

    // Wait for a status bit, counting cycles
    task automatic wait_ev(input int idx, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (status[idx] !== 1'b1 && n < 1000);
        if (status[idx] !== 1'b1) begin
            err_count++;
            $display("[ERR] t=%0t status event %0d missing", $time, idx);
        end
    endtask

    // Pin falls three cycles after convDone, two after the store
    task automatic chk_fall();
        repeat (2) @(posedge clk);
        #1 chk(dataOutReadyN, 1'b1);
        @(posedge clk);
        #1 chk(dataOutReadyN, 1'b0);
    endtask

    task automatic t_settle_cadence();
        int n;
        for (int k = 1; k <= 5; k++) begin
            wait_ev(3, n);
            if (k > 1) chk(n, 384);
            if (k >= 4) chk(status.settled, 1'b0);
        end
        repeat (3) @(posedge clk);
        #1 chk(status.settled, 1'b1);
        wait_ev(4, n);
        wait_ev(4, n);
        chk(n, 6);
    endtask

    // Newer word replaces an unread one
    task automatic t_overwrite();
        int n;
        @(posedge clk);
        filterWord <= 24'hc3a51e;
        wait_ev(3, n);
        repeat (4) @(posedge clk);
        #1 chk(dataOutReadyN, 1'b0);
        host_reader_model_i.read_bits(RESULT_W, 2, got);
        chk(got, 24'hc3a51e);
    endtask

    task automatic t_read(input logic [RESULT_W-1:0] word, input int half);
        int n;
        @(posedge clk);
        filterWord <= word;
        wait_ev(3, n);
        chk_fall();
        host_reader_model_i.read_bits(RESULT_W, half, got);
        chk(got, word);
        repeat (2) @(posedge clk);
        #1 chk(dataOutReadyN, 1'b1);
    endtask

    // Word stored during a read keeps the pin low afterwards
    task automatic t_mid_read();
        int n;
        @(posedge clk);
        filterWord <= 24'h13579b;
        wait_ev(3, n);
        @(posedge clk);
        filterWord <= 24'h2468ac;
        repeat (RESULT_CLKS - 60) @(posedge clk);
        host_reader_model_i.read_bits(RESULT_W, 2, got);
        chk(got, 24'h13579b);
        repeat (2) @(posedge clk);
        #1 chk(dataOutReadyN, 1'b0);
        host_reader_model_i.read_bits(RESULT_W, 2, got);
        chk(got, 24'h2468ac);
    endtask

    // Abort with sync, short hold, then power-down
    task automatic t_halt();
        int n;
        @(posedge clk);
        filterWord <= 24'h5a5a5a;
        wait_ev(3, n);
        chk_fall();
        host_reader_model_i.read_bits(4, 2, got);
        chk(got[3:0], 4'h5);
        modCnt = 0;
        pdCnt = 0;
        host_reader_model_i.hold_high(SYNC_T + 2);
        repeat (2) @(posedge clk);
        #1 chk(modCnt, 1);
        chk(pdCnt, 0);
        chk(dataOutReadyN, 1'b1);
        chk(status.settled, 1'b0);
        host_reader_model_i.hold_high(SYNC_T - 1);
        repeat (2) @(posedge clk);
        #1 chk(modCnt, 1);
        host_reader_model_i.hold_high(PD_T + 4);
        repeat (3) @(posedge clk);
        #1 chk(modCnt, 2);
        chk(pdCnt, 5);
        chk(status.powerDown, 1'b0);
        wait_ev(3, n);
        chk_fall();
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (12000) @(posedge clk);
        err_count++;
        $display("[ERR] t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        srst = 1'b1;
        filterWord = 24'h000000;
        modCnt = 0;
        pdCnt = 0;
        err_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        t_settle_cadence();
        t_overwrite();
        t_read(24'h800001, 2);
        t_read(24'h7ffffe, 5);
        t_mid_read();
        t_halt();
        tally_and_finish();
    end
endmodule
